// >>> verilog/acrb_pkg.sv
// Constants and carrier types shared by the accelerometer control register bank.
package acrb_pkg;

  // ==========================================================================
  // Register addresses
  localparam logic [6:0] ADDR_EXT_FIRST   = 7'h06;
  localparam logic [6:0] ADDR_EXT_LAST    = 7'h0B;
  localparam logic [6:0] ADDR_MAGNITUDE   = 7'h0C;
  localparam logic [6:0] ADDR_IDENTITY    = 7'h0F;
  localparam logic [6:0] ADDR_RATE_RANGE  = 7'h20;
  localparam logic [6:0] ADDR_SYS_IF      = 7'h21;
  localparam logic [6:0] ADDR_OUT_FIRST   = 7'h28;
  localparam logic [6:0] ADDR_OUT_LAST    = 7'h2D;
  localparam logic [6:0] ADDR_ADV_FIRST   = 7'h2B;
  localparam logic [6:0] ADDR_ADV_LAST    = 7'h3F;

  // ==========================================================================
  // Field positions and reset values
  localparam int         RR_RATE_LSB       = 4;
  localparam int         RR_RANGE_LSB      = 2;
  localparam int         RR_HF_BIT         = 1;
  localparam int         RR_HOLD_BIT       = 0;
  localparam int         SI_REBOOT_BIT     = 7;
  localparam int         SI_SOFT_RESET_BIT = 6;
  localparam int         SI_ADV_BIT        = 4;
  localparam int         SI_FILTER_BIT     = 3;
  localparam int         SI_AUTO_INC_BIT   = 2;
  localparam int         SI_I2C_DIS_BIT    = 1;
  localparam int         SI_THREE_WIRE_BIT = 0;
  localparam logic [7:0] RATE_RANGE_RESET  = 8'h00;
  localparam logic [7:0] SYS_IF_RESET      = 8'h04;

  // ==========================================================================
  // Mode decode tables, rates in tenths of a hertz
  localparam logic [3:0] RATE_POWER_DOWN = 4'h0;
  localparam logic [3:0] RATE_HF_FIRST   = 4'h5;
  localparam logic [4:0] RES_LOW_POWER   = 5'h0A;
  localparam logic [4:0] RES_HIGH_FREQ   = 5'h0C;
  localparam logic [4:0] RES_HIGH_RES    = 5'h0E;
  localparam logic [15:0] LP_RATE_DHZ [8] = '{16'h000A, 16'h007D, 16'h00FA, 16'h01F4,
                                              16'h03E8, 16'h07D0, 16'h0FA0, 16'h1F40};
  localparam logic [15:0] HR_RATE_DHZ [8] = '{16'h0000, 16'h007D, 16'h00FA, 16'h01F4,
                                              16'h03E8, 16'h07D0, 16'h0FA0, 16'h1F40};
  localparam logic [15:0] HF_RATE_DHZ [8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
                                              16'h0000, 16'h3E80, 16'h7D00, 16'hFA00};
  localparam logic [4:0]  RANGE_G [4]     = '{5'h02, 5'h10, 5'h04, 5'h08};

  // ==========================================================================
  // Serial framing
  localparam logic [2:0] BIT_LAST = 3'h7;

  // ==========================================================================
  // Types
  typedef enum logic [1:0] {
    power_down_mode,
    low_power_mode,
    high_resolution_mode,
    high_frequency_mode
  } acrb_mode_t;

  typedef struct packed {
    logic [15:0] x;
    logic [15:0] y;
    logic [15:0] z;
  } acrb_sample_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } acrb_access_t;

  typedef struct packed {
    acrb_mode_t  mode;
    logic [4:0]  resolution;
    logic [15:0] rate_dhz;
    logic [4:0]  range_g;
  } acrb_config_t;

endpackage : acrb_pkg

// >>> verilog/acrb_spi_port.sv
// Serial register port: frames SPI commands into register accesses.
`timescale 1ns/10ps

module acrb_spi_port (
  input  wire logic                   clk_i,
  input  wire logic                   rst_b_i,
  input  wire logic                   sck_i,
  input  wire logic                   cs_b_i,
  input  wire logic                   sdi_i,
  input  wire logic                   three_wire_i,
  input  wire logic                   auto_inc_i,
  input  wire logic [7:0]             rd_data_i,
  output logic                        sdo_o,
  output logic                        sdo_oe_o,
  output logic                        sdio_o,
  output logic                        sdio_oe_o,
  output acrb_pkg::acrb_access_t      access_o
);

  logic       sck_q;
  logic       in_data;
  logic       is_read;
  logic       out_bit;
  logic [2:0] bit_cnt;
  logic [6:0] addr;
  logic [6:0] addr_inc;
  logic [7:0] shift_in;
  logic [7:0] shift_next;
  logic [7:0] shift_out;
  logic       rise;
  logic       fall;
  logic       byte_end;
  logic       cmd_end;
  logic       data_end;
  logic       drive;

  // ==========================================================================
  // Edge detection and framing
  assign rise       = !cs_b_i && sck_i && !sck_q;
  assign fall       = !cs_b_i && !sck_i && sck_q;
  assign shift_next = {shift_in[6:0], sdi_i};
  assign byte_end   = rise && (bit_cnt == acrb_pkg::BIT_LAST);
  assign cmd_end    = byte_end && !in_data;
  assign data_end   = byte_end && in_data;
  assign addr_inc   = auto_inc_i ? addr + 7'h01 : addr;

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      sck_q <= 1'b1;
    else
      sck_q <= sck_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i || cs_b_i)
    begin
      bit_cnt  <= 3'h0;
      in_data  <= 1'b0;
      is_read  <= 1'b0;
      shift_in <= 8'h00;
      addr     <= 7'h00;
    end
    else if (rise)
    begin
      bit_cnt  <= bit_cnt + 3'h1;
      shift_in <= shift_next;
      if (cmd_end)
      begin
        in_data <= 1'b1;
        is_read <= shift_next[7];
        addr    <= shift_next[6:0];
      end
      else if (data_end)
        addr <= addr_inc;
    end
  end

  // ==========================================================================
  // Access strobes, one cycle after the closing edge of a byte
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      access_o <= '0;
    else
    begin
      access_o.rd    <= (cmd_end && shift_next[7]) || (data_end && is_read);
      access_o.wr    <= data_end && !is_read;
      access_o.addr  <= cmd_end ? shift_next[6:0] : (is_read ? addr_inc : addr);
      access_o.wdata <= shift_next;
    end
  end

  // Read data leave most significant bit first, changed on falling edges.
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i || cs_b_i)
    begin
      shift_out <= 8'h00;
      out_bit   <= 1'b0;
    end
    else if (access_o.rd)
      shift_out <= rd_data_i;
    else if (fall && in_data && is_read)
    begin
      out_bit   <= shift_out[7];
      shift_out <= {shift_out[6:0], 1'b0};
    end
  end

  assign drive     = !cs_b_i && in_data && is_read;
  assign sdo_oe_o  = drive && !three_wire_i;
  assign sdio_oe_o = drive && three_wire_i;
  assign sdo_o     = out_bit;
  assign sdio_o    = out_bit;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_read_cmd;
    (cmd_end && shift_next[7]) |=> (access_o.rd && access_o.addr == $past(shift_next[6:0]));
  endproperty
  a_read_cmd: assert property (p_read_cmd) else $error("read command not issued");

  property p_wire_mode;
    (cmd_end && shift_next[7]) ##1 !cs_b_i
      |-> (three_wire_i ? (sdio_oe_o && !sdo_oe_o) : (sdo_oe_o && !sdio_oe_o));
  endproperty
  a_wire_mode: assert property (p_wire_mode) else $error("wrong data line driven");

  property p_addr_fixed;
    (data_end && is_read && !auto_inc_i) |=> (access_o.addr == $past(addr));
  endproperty
  a_addr_fixed: assert property (p_addr_fixed) else $error("address moved");

endmodule : acrb_spi_port

// >>> verilog/acrb_register_bank.sv
// Basic register bank of a three-axis accelerometer, reached over SPI.
`timescale 1ns/10ps

// Function
// - Calibration reloads at power-up; host leaves it.
// - Six external sensor bytes at 06h-0Bh.
// - Read-only magnitude byte at 0Ch, resets zero.
// - Fixed identity at 0Fh, writes ignored.
// - Rate, range, high-frequency, hold fields, reset zero.
// - Range codes map to 2, 16, 4, 8 g.
// - Rate code zero powers down, no samples.
// - Codes 1000-1111 low power, ten bits.
// - Codes 0101-0111: high-frequency bit picks mode.
// - Hold clear: outputs follow every sample.
// - Hold set: pair frozen until both read; auto-increment look-ahead reads count.
// - Reboot bit reloads trimming; rate-range settings are kept.
// - Soft reset restores control defaults, self-clears.
// - Advanced bank: only 2Bh-3Fh writable.
// - Filter select picks high-pass data.
// - Auto-increment advances address per byte.
// - I2C disable leaves only SPI usable.
// - Three-wire bit selects SPI wiring.
// - Read frame: flag, address, data MSB first.
module acrb_register_bank #(
  parameter logic [7:0] IDENTITY_CODE = 8'h5A  // Arbitrary value.
) (
  input  wire logic                   clk_i,
  input  wire logic                   rst_b_i,
  input  wire logic                   spi_sck_i,
  input  wire logic                   spi_cs_b_i,
  input  wire logic                   spi_sdi_i,
  output logic                        spi_sdo_o,
  output logic                        spi_sdo_oe_o,
  output logic                        spi_sdio_o,
  output logic                        spi_sdio_oe_o,
  input  wire acrb_pkg::acrb_sample_t raw_sample_i,
  input  wire acrb_pkg::acrb_sample_t filtered_sample_i,
  input  wire logic                   sample_valid_i,
  input  wire logic [7:0]             magnitude_i,
  input  wire logic [5:0][7:0]        ext_bytes_i,
  input  wire logic                   ext_valid_i,
  input  wire logic [7:0]             adv_rdata_i,
  input  wire logic                   adv_bank_clear_i,
  output acrb_pkg::acrb_access_t      adv_access_o,
  output logic                        boot_load_o,
  input  wire logic                   boot_done_i,
  output logic                        i2c_enable_o,
  output logic                        filter_select_o,
  output acrb_pkg::acrb_config_t      config_o
);

  acrb_pkg::acrb_access_t acc;
  acrb_pkg::acrb_sample_t latest;
  acrb_pkg::acrb_sample_t sel_sample;
  logic [7:0]             rate_range_control;
  logic [7:0]             system_interface_control;
  logic [4:0]             sys_bits;
  logic                   reboot_req;
  logic                   power_up_boot;
  logic [5:0][7:0]        ext_reg;
  logic [7:0]             magnitude_value;
  logic [15:0]            out_axis [3];
  logic [15:0]            latest_axis [3];
  logic [7:0]             read_data;
  logic [6:0]             ext_off;
  logic [6:0]             out_off;
  logic [3:0]             rate_code;
  logic                   adv_on;
  logic                   adv_window;
  logic                   ctrl_wr;
  logic                   rr_wr;
  logic                   si_wr;
  logic                   soft_reset_hit;
  logic                   reboot_write;
  logic                   hold;
  logic                   power_down;
  logic                   sample_take;
  logic                   out_rd;

  // ==========================================================================
  // Serial port
  acrb_spi_port u_spi (
    .clk_i        (clk_i),
    .rst_b_i      (rst_b_i),
    .sck_i        (spi_sck_i),
    .cs_b_i       (spi_cs_b_i),
    .sdi_i        (spi_sdi_i),
    .three_wire_i (sys_bits[acrb_pkg::SI_THREE_WIRE_BIT]),
    .auto_inc_i   (sys_bits[acrb_pkg::SI_AUTO_INC_BIT]),
    .rd_data_i    (read_data),
    .sdo_o        (spi_sdo_o),
    .sdo_oe_o     (spi_sdo_oe_o),
    .sdio_o       (spi_sdio_o),
    .sdio_oe_o    (spi_sdio_oe_o),
    .access_o     (acc)
  );

  // ==========================================================================
  // Access decode
  assign adv_on     = sys_bits[acrb_pkg::SI_ADV_BIT];
  assign adv_window = adv_on && (acc.addr >= acrb_pkg::ADDR_ADV_FIRST)
                      && (acc.addr <= acrb_pkg::ADDR_ADV_LAST);
  // Writes to reserved, read-only and unmapped addresses simply fall through.
  assign ctrl_wr        = acc.wr && !adv_on;
  assign rr_wr          = ctrl_wr && (acc.addr == acrb_pkg::ADDR_RATE_RANGE);
  assign si_wr          = ctrl_wr && (acc.addr == acrb_pkg::ADDR_SYS_IF);
  assign soft_reset_hit = si_wr && acc.wdata[acrb_pkg::SI_SOFT_RESET_BIT];
  assign reboot_write   = si_wr && acc.wdata[acrb_pkg::SI_REBOOT_BIT];
  assign out_rd         = acc.rd && !adv_window;

  // The advanced bank answers in the same cycle from this combinational view.
  assign adv_access_o = '{rd:    acc.rd && adv_window,
                          wr:    acc.wr && adv_window,
                          addr:  acc.addr,
                          wdata: acc.wdata};

  // ==========================================================================
  // Control registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i || soft_reset_hit)
      rate_range_control <= acrb_pkg::RATE_RANGE_RESET;
    else if (rr_wr)
      rate_range_control <= acc.wdata;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i || soft_reset_hit)
      sys_bits <= acrb_pkg::SYS_IF_RESET[4:0];
    else if (si_wr)
      sys_bits <= acc.wdata[4:0];
    else if (adv_bank_clear_i)
      sys_bits[acrb_pkg::SI_ADV_BIT] <= 1'b0;
  end

  // A new reboot request wins over a completion seen in the same cycle.
  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      reboot_req <= 1'b0;
    else if (reboot_write)
      reboot_req <= 1'b1;
    else if (boot_done_i)
      reboot_req <= 1'b0;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      power_up_boot <= 1'b1;
    else if (boot_done_i)
      power_up_boot <= 1'b0;
  end

  assign boot_load_o = power_up_boot || reboot_req;
  // Soft reset and the fixed bit five always read back as zero.
  assign system_interface_control = {reboot_req, 1'b0, 1'b0, sys_bits};
  assign i2c_enable_o    = !sys_bits[acrb_pkg::SI_I2C_DIS_BIT];
  assign filter_select_o = sys_bits[acrb_pkg::SI_FILTER_BIT];
  assign hold            = rate_range_control[acrb_pkg::RR_HOLD_BIT];
  assign rate_code       = rate_range_control[acrb_pkg::RR_RATE_LSB +: 4];

  // ==========================================================================
  // Mode decode
  function automatic acrb_pkg::acrb_config_t decode_config(
    input logic [3:0] code,
    input logic       hf,
    input logic [1:0] range
  );
    acrb_pkg::acrb_config_t cfg;
    cfg         = '0;
    cfg.range_g = acrb_pkg::RANGE_G[range];
    if (code == acrb_pkg::RATE_POWER_DOWN)
      cfg.mode = acrb_pkg::power_down_mode;
    else if (code[3])
    begin
      cfg.mode       = acrb_pkg::low_power_mode;
      cfg.resolution = acrb_pkg::RES_LOW_POWER;
      cfg.rate_dhz   = acrb_pkg::LP_RATE_DHZ[code[2:0]];
    end
    else if (hf && (code >= acrb_pkg::RATE_HF_FIRST))
    begin
      cfg.mode       = acrb_pkg::high_frequency_mode;
      cfg.resolution = acrb_pkg::RES_HIGH_FREQ;
      cfg.rate_dhz   = acrb_pkg::HF_RATE_DHZ[code[2:0]];
    end
    else
    begin
      cfg.mode       = acrb_pkg::high_resolution_mode;
      cfg.resolution = acrb_pkg::RES_HIGH_RES;
      cfg.rate_dhz   = acrb_pkg::HR_RATE_DHZ[code[2:0]];
    end
    return cfg;
  endfunction : decode_config

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      config_o <= '0;
    else
      config_o <= decode_config(rate_code, rate_range_control[acrb_pkg::RR_HF_BIT],
                                rate_range_control[acrb_pkg::RR_RANGE_LSB +: 2]);
  end

  // ==========================================================================
  // Sample capture
  assign power_down  = (rate_code == acrb_pkg::RATE_POWER_DOWN);
  assign sample_take = sample_valid_i && !power_down;
  assign sel_sample  = filter_select_o ? filtered_sample_i : raw_sample_i;

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      latest <= '0;
    else if (sample_take)
      latest <= sel_sample;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      magnitude_value <= 8'h00;
    else if (sample_take)
      magnitude_value <= magnitude_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_b_i)
      ext_reg <= '0;
    else if (ext_valid_i)
      ext_reg <= ext_bytes_i;
  end

  assign latest_axis = '{latest.x, latest.y, latest.z};

  // ==========================================================================
  // Output pairs with update hold
  for (genvar g = 0; g < 3; g++)
  begin : g_axis
    localparam logic [6:0] LO_ADDR = 7'(acrb_pkg::ADDR_OUT_FIRST + 2 * g);
    logic lo_hit;
    logic hi_hit;
    logic seen_lo;
    logic seen_hi;
    logic freeze;

    assign lo_hit = out_rd && (acc.addr == LO_ADDR);
    assign hi_hit = out_rd && (acc.addr == LO_ADDR + 7'h01);
    // The read cycle itself is frozen too, or the second byte could tear.
    assign freeze = hold && (seen_lo || seen_hi || lo_hit || hi_hit);

    always_ff @(posedge clk_i)
    begin
      if (!rst_b_i || !hold)
      begin
        seen_lo <= 1'b0;
        seen_hi <= 1'b0;
      end
      else if ((seen_lo || lo_hit) && (seen_hi || hi_hit))
      begin
        seen_lo <= 1'b0;
        seen_hi <= 1'b0;
      end
      else
      begin
        if (lo_hit)
          seen_lo <= 1'b1;
        if (hi_hit)
          seen_hi <= 1'b1;
      end
    end

    always_ff @(posedge clk_i)
    begin
      if (!rst_b_i)
        out_axis[g] <= 16'h0000;
      else if (!freeze)
        out_axis[g] <= latest_axis[g];
    end
  end

  // ==========================================================================
  // Read multiplexer; unmapped and reserved addresses read as zero
  assign ext_off = acc.addr - acrb_pkg::ADDR_EXT_FIRST;
  assign out_off = acc.addr - acrb_pkg::ADDR_OUT_FIRST;

  always_comb
  begin
    read_data = 8'h00;
    if (adv_window)
      read_data = adv_rdata_i;
    else if ((acc.addr >= acrb_pkg::ADDR_EXT_FIRST) && (acc.addr <= acrb_pkg::ADDR_EXT_LAST))
      read_data = ext_reg[ext_off[2:0]];
    else if (acc.addr == acrb_pkg::ADDR_MAGNITUDE)
      read_data = magnitude_value;
    else if (acc.addr == acrb_pkg::ADDR_IDENTITY)
      read_data = IDENTITY_CODE;
    else if (acc.addr == acrb_pkg::ADDR_RATE_RANGE)
      read_data = rate_range_control;
    else if (acc.addr == acrb_pkg::ADDR_SYS_IF)
      read_data = system_interface_control;
    else if ((acc.addr >= acrb_pkg::ADDR_OUT_FIRST) && (acc.addr <= acrb_pkg::ADDR_OUT_LAST))
      read_data = out_off[0] ? out_axis[out_off[2:1]][15:8] : out_axis[out_off[2:1]][7:0];
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_identity;
    (acc.rd && acc.addr == acrb_pkg::ADDR_IDENTITY && !adv_on) |-> (read_data == IDENTITY_CODE);
  endproperty
  a_identity: assert property (p_identity) else $error("identity read wrong");

  property p_power_down;
    (power_down && sample_valid_i) |=> $stable(latest);
  endproperty
  a_power_down: assert property (p_power_down) else $error("sample in power-down");

  property p_low_power;
    rate_code[3] |=> (config_o.mode == acrb_pkg::low_power_mode && config_o.resolution == 5'h0A);
  endproperty
  a_low_power: assert property (p_low_power) else $error("low-power decode wrong");

  property p_high_res;
    (rate_code >= 4'h1 && rate_code <= 4'h4)
      |=> (config_o.mode == acrb_pkg::high_resolution_mode && config_o.resolution == 5'h0E);
  endproperty
  a_high_res: assert property (p_high_res) else $error("high-resolution decode wrong");

  property p_high_freq;
    (rate_code >= 4'h5 && rate_code <= 4'h7 && rate_range_control[acrb_pkg::RR_HF_BIT])
      |=> (config_o.mode == acrb_pkg::high_frequency_mode && config_o.resolution == 5'h0C);
  endproperty
  a_high_freq: assert property (p_high_freq) else $error("high-frequency decode wrong");

  property p_range_16g;
    (rate_range_control[3:2] == 2'b01) |=> (config_o.range_g == 5'h10);
  endproperty
  a_range_16g: assert property (p_range_16g) else $error("range decode wrong");

  property p_soft_reset;
    soft_reset_hit |=> (rate_range_control == 8'h00 && system_interface_control[6:0] == 7'h04);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset incomplete");

  property p_adv_lock;
    (acc.wr && adv_on && acc.addr == acrb_pkg::ADDR_RATE_RANGE) |=> $stable(rate_range_control);
  endproperty
  a_adv_lock: assert property (p_adv_lock) else $error("write passed in advanced bank");

  property p_filter;
    (sample_take && filter_select_o) |=> (latest == $past(filtered_sample_i));
  endproperty
  a_filter: assert property (p_filter) else $error("filtered data not used");

  property p_reboot_done;
    (reboot_req && boot_done_i && !reboot_write) |=> (!reboot_req && !boot_load_o);
  endproperty
  a_reboot_done: assert property (p_reboot_done) else $error("reboot bit stuck");

  property p_continuous;
    (sample_take && !hold) ##1 !hold |=> (out_axis[0] == $past(sel_sample.x, 2));
  endproperty
  a_continuous: assert property (p_continuous) else $error("output not refreshed");

  sequence s_low_taken;
    hold && g_axis[0].lo_hit && !g_axis[0].seen_hi;
  endsequence
  sequence s_high_pending;
    hold && !g_axis[0].hi_hit;
  endsequence
  property p_hold_pair;
    s_low_taken ##1 s_high_pending |=> $stable(out_axis[0]);
  endproperty
  a_hold_pair: assert property (p_hold_pair) else $error("held pair changed");

endmodule : acrb_register_bank

// >>> tb/acrb_spi_host.sv
// Host processor model that frames register accesses on the serial port.
`timescale 1ns/10ps

module acrb_spi_host (
  input  wire logic clk_i,
  input  wire logic sdo_i,
  output logic      sck_o,
  output logic      cs_b_o,
  output logic      sdi_o
);
  // ==========================================================================
  // Frame driver
  initial
  begin
    sck_o = 1'b1;
    cs_b_o = 1'b1;
    sdi_o = 1'b0;
  end

  // Low and high phases of three and four clocks meet the port's two-clock minimum.
  task automatic xfer(input logic [15:0] f, output logic [7:0] d);
    d = 8'h00;
    @(posedge clk_i) cs_b_o <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      @(posedge clk_i) sck_o <= 1'b0;
      sdi_o <= f[i];
      repeat (3) @(posedge clk_i);
      sck_o <= 1'b1;
      if (i < 8)
        d = {d[6:0], sdo_i};
      repeat (3) @(posedge clk_i);
    end
    @(posedge clk_i) cs_b_o <= 1'b1;
    sdi_o <= ~sdi_o;
    repeat (2) @(posedge clk_i);
  endtask : xfer
endmodule : acrb_spi_host

// >>> tb/accel_control_register_bank_bench.sv
// Self-checking bench for the accelerometer control register bank.
`timescale 1ns/10ps

module accel_control_register_bank_bench;
  logic clk = 1'b0, rst_b = 1'b0, three_w = 1'b0, sv = 1'b0, ev = 1'b0, bd = 1'b0;
  logic sck, cs_b, sdi, sdo, so, so_oe, sio, sio_oe, boot, i2c_en, filt;
  logic [7:0] mag = 8'h00;
  logic [5:0][7:0] ext = '0;
  acrb_pkg::acrb_sample_t raw = '0;
  acrb_pkg::acrb_config_t cfg;
  acrb_pkg::acrb_access_t adv_acc;
  logic ac = 1'b0;
  logic [7:0] adv_d = 8'hC3;
  int checks = 0, n_fail = 0, n_adv = 0;

  // ==========================================================================
  // Harness
  always #4 clk = ~clk;
  assign sdo = three_w ? (sio_oe ? sio : 1'bz) : (so_oe ? so : 1'bz);
  acrb_register_bank acrb_register_bank_i (.clk_i(clk), .rst_b_i(rst_b), .spi_sck_i(sck),
    .spi_cs_b_i(cs_b), .spi_sdi_i(sdi), .spi_sdo_o(so), .spi_sdo_oe_o(so_oe),
    .spi_sdio_o(sio), .spi_sdio_oe_o(sio_oe), .raw_sample_i(raw), .filtered_sample_i(~raw),
    .sample_valid_i(sv), .magnitude_i(mag), .ext_bytes_i(ext), .ext_valid_i(ev),
    .adv_rdata_i(adv_d), .adv_bank_clear_i(ac), .adv_access_o(adv_acc), .boot_load_o(boot),
    .boot_done_i(bd), .i2c_enable_o(i2c_en), .filter_select_o(filt), .config_o(cfg));
  acrb_spi_host acrb_spi_host_i (.clk_i(clk), .sdo_i(sdo), .sck_o(sck), .cs_b_o(cs_b),
    .sdi_o(sdi));

  // Counts write strobes handed to the advanced bank.
  always @(posedge clk)
    if (adv_acc.wr === 1'b1)
      n_adv <= n_adv + 1;

  task automatic chk(input logic [27:0] g, input logic [27:0] e);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    logic [7:0] d;
    acrb_spi_host_i.xfer({1'b0, a, v}, d);
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] d;
    acrb_spi_host_i.xfer({1'b1, a, 8'h00}, d);
    chk({20'h0, d}, {20'h0, e});
  endtask : rd

  task automatic smp(input logic [47:0] r, input logic [7:0] m);
    @(posedge clk) raw <= r;
    mag <= m;
    sv <= 1'b1;
    @(posedge clk) sv <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : smp

  task automatic complete_run;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  // A hung transfer ends the run as a mismatch.
  initial
  begin
    repeat (20000) @(posedge clk);
    n_fail++;
    complete_run();
  end

  initial
  begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk) chk({27'h0, boot}, 28'h1);
    bd <= 1'b1;
    @(posedge clk) bd <= 1'b0;
    @(posedge clk) chk({27'h0, boot}, 28'h0);
    wr(7'h0F, 8'h00);
    rd(7'h0F, 8'h5A);
    rd(7'h20, 8'h00);
    rd(7'h21, 8'h04);
    for (int k = 0; k < 6; k++)
      ext[k] <= 8'hA0 + 8'(k);
    @(posedge clk) ev <= 1'b1;
    @(posedge clk) ev <= 1'b0;
    for (int k = 0; k < 6; k++)
      rd(7'h06 + 7'(k), 8'hA0 + 8'(k));
    smp(48'h1234_5678_9ABC, 8'h3C);
    rd(7'h0C, 8'h00);
    wr(7'h20, 8'h97);
    chk(cfg, {acrb_pkg::low_power_mode, 5'h0A, 16'h007D, 5'h10});
    $display("identity and config test done");
    wr(7'h21, 8'h00);
    smp(48'h1234_5678_9ABC, 8'h3C);
    rd(7'h0C, 8'h3C);
    rd(7'h28, 8'h34);
    smp(48'hABCD_0000_0000, 8'h11);
    rd(7'h29, 8'h12);
    rd(7'h28, 8'hCD);
    $display("output hold test done");
    wr(7'h21, 8'h0E);
    chk({26'h0, filt, i2c_en}, 28'h2);
    smp(48'h1234_5678_9ABC, 8'h3C);
    rd(7'h2C, 8'h43);
    wr(7'h21, 8'h05);
    three_w <= 1'b1;
    rd(7'h0F, 8'h5A);
    three_w <= 1'b0;
    wr(7'h21, 8'h4A);
    rd(7'h20, 8'h00);
    rd(7'h21, 8'h04);
    wr(7'h20, 8'h36);
    chk(cfg, {acrb_pkg::high_resolution_mode, 5'h0E, 16'h01F4, 5'h10});
    smp(48'h1234_5678_9ABC, 8'h00);
    rd(7'h2A, 8'h78);
    wr(7'h20, 8'h7E);
    chk(cfg, {acrb_pkg::high_frequency_mode, 5'h0C, 16'hFA00, 5'h08});
    wr(7'h20, 8'h70);
    chk(cfg, {acrb_pkg::high_resolution_mode, 5'h0E, 16'h1F40, 5'h02});
    $display("mode decode test done");
    wr(7'h21, 8'h14);
    rd(7'h3F, 8'hC3);
    wr(7'h3F, 8'h00);
    @(posedge clk) ac <= 1'b1;
    @(posedge clk) ac <= 1'b0;
    chk(28'(n_adv), 28'h1);
    rd(7'h21, 8'h04);
    $display("advanced bank test done");
    wr(7'h21, 8'h80);
    chk({27'h0, boot}, 28'h1);
    rd(7'h21, 8'h80);
    @(posedge clk) bd <= 1'b1;
    @(posedge clk) bd <= 1'b0;
    rd(7'h21, 8'h00);
    $display("system control test done");
    complete_run();
  end
endmodule : accel_control_register_bank_bench
